// ==== rtl/i2c_byte_engine_pkg.sv ====
/*
 * Shared constants for the two-wire master byte engine: state codes, field
 * widths, bit indices, reset values and buffer depth.
 * Assumes a single 100 MHz system clock domain; no bus, plain ports only.
 */
package i2c_byte_engine_pkg;

   localparam int unsigned CLK_PERIOD_NS  = 10;
   localparam int unsigned BYTE_W         = 8;
   localparam int unsigned TIMER_W        = 8;
   localparam int unsigned BIT_CNT_W      = 4;
   localparam int unsigned RX_FIFO_DEPTH  = 2;

   // Bit counter values: last data bit and acknowledge clock
   localparam logic [BIT_CNT_W-1:0] LAST_DATA_IDX = 4'h7;
   localparam logic [BIT_CNT_W-1:0] ACK_CLK_IDX   = 4'h8;
   localparam logic [BIT_CNT_W-1:0] BIT_CNT_RST   = 4'h0;

   localparam logic [TIMER_W-1:0]   TIMER_RST     = 8'h00;
   localparam logic [BYTE_W-1:0]    BYTE_RST      = 8'h00;
   localparam logic [1:0]           FIFO_CNT_FULL = 2'h2;

   // Gray codes along the usual path
   typedef enum logic [3:0] {
      ST_IDLE      = 4'h0,
      ST_TX_LOW    = 4'h1,
      ST_TX_HIGH   = 4'h3,
      ST_RX_LOW    = 4'h2,
      ST_RX_HIGH   = 4'h6,
      ST_ACK_LOW   = 4'h7,
      ST_ACK_HIGH  = 4'h5,
      ST_STOP_SDA  = 4'h4,
      ST_STOP_LOW  = 4'hC,
      ST_STOP_HIGH = 4'hD,
      ST_STOP_WAIT = 4'hF,
      ST_STOP_END  = 4'hE,
      ST_RS_LOW    = 4'hA,
      ST_RS_SDA    = 4'hB,
      ST_RS_SCL    = 4'h9,
      ST_RS_SDA_LO = 4'h8
   } engine_state_t;

endpackage : i2c_byte_engine_pkg

// ==== rtl/i2c_master_byte_engine.sv ====
/*
 * Master-side two-wire byte engine: transmit with acknowledge capture,
 * receive, master acknowledge, stop and repeated start, timed by a
 * reloadable bit timer. Received bytes also leave through a two-entry
 * valid/ready buffer.
 * Assumes: SCL/SDA are open-drain wires resolved outside (oe high pulls the
 * line low); scl_in/sda_in are asynchronous; start generation is done
 * elsewhere, so a transmit begins with SCL already held low.
 */
`timescale 1ns/1ps

module i2c_master_byte_engine (
   // Clock and reset
   input  wire logic                                    clk_in,
   input  wire logic                                    reset_n_in,
   // Bus pins
   input  wire logic                                    scl_in,
   output logic                                         scl_out,
   output logic                                         scl_oe_out,
   input  wire logic                                    sda_in,
   output logic                                         sda_out,
   output logic                                         sda_oe_out,
   // Holding buffer access
   input  wire logic                                    holding_buffer_wr_in,
   input  wire logic [i2c_byte_engine_pkg::BYTE_W-1:0]  holding_buffer_wdata_in,
   input  wire logic                                    holding_buffer_rd_in,
   output logic [i2c_byte_engine_pkg::BYTE_W-1:0]       holding_buffer_out,
   // Configuration and request pulses
   input  wire logic [i2c_byte_engine_pkg::TIMER_W-1:0] bit_timer_reload_in,
   input  wire logic                                    ack_value_bit_in,
   input  wire logic                                    restart_request_set_in,
   input  wire logic                                    stop_request_set_in,
   input  wire logic                                    receive_request_set_in,
   input  wire logic                                    ack_sequence_request_set_in,
   // Flag clear pulses
   input  wire logic                                    serial_event_flag_clr_in,
   input  wire logic                                    write_collision_flag_clr_in,
   input  wire logic                                    receive_overflow_flag_clr_in,
   input  wire logic                                    collision_flag_clr_in,
   input  wire logic                                    stop_seen_clr_in,
   // Status
   output logic                                         buffer_full_flag_out,
   output logic                                         write_collision_flag_out,
   output logic                                         ack_result_flag_out,
   output logic                                         serial_event_flag_out,
   output logic                                         receive_overflow_flag_out,
   output logic                                         collision_flag_out,
   output logic                                         stop_seen_out,
   output logic                                         restart_request_out,
   output logic                                         stop_request_out,
   output logic                                         receive_request_out,
   output logic                                         ack_sequence_request_out,
   output logic                                         busy_out,
   // Received byte stream
   output logic                                         rx_valid_out,
   input  wire logic                                    rx_ready_in,
   output logic [i2c_byte_engine_pkg::BYTE_W-1:0]       rx_data_out
);
   import i2c_byte_engine_pkg::*;

   typedef struct packed {
      engine_state_t                   state;
      logic                            scl_s1;
      logic                            scl_s2;
      logic                            sda_s1;
      logic                            sda_s2;
      logic                            scl_prev;
      logic                            scl_low;
      logic                            sda_low;
      logic [TIMER_W-1:0]              tmr;
      logic                            timer_run;
      logic [BIT_CNT_W-1:0]            bit_cnt;
      logic [BYTE_W-1:0]               shift_register;
      logic [BYTE_W-1:0]               holding_buffer;
      logic                            bf;
      logic                            write_collision_flag;
      logic                            ack_result;
      logic                            evt;
      logic                            ov;
      logic                            coll;
      logic                            stop_seen;
      logic                            restart_request;
      logic                            stop_request;
      logic                            receive_request;
      logic                            ack_sequence_request;
      logic [RX_FIFO_DEPTH-1:0][BYTE_W-1:0] fifo_mem;
      logic                            fifo_wr;
      logic                            fifo_rd;
      logic [1:0]                      fifo_cnt;
   } engine_t;

   engine_t s_r;
   engine_t s_nxt;

   logic scl_hi;
   logic sda_hi;
   logic stall;
   logic tick;
   logic reload;
   logic halt;
   logic idle;
   logic evt_set;
   logic write_collision_flag_set;
   logic bf_set;
   logic bf_clr;
   logic ov_set;
   logic coll_set;
   logic push;
   logic pop;

   always_comb begin
      s_nxt    = s_r;
      reload   = 1'b0;
      halt     = 1'b0;
      evt_set  = 1'b0;
      write_collision_flag_set = 1'b0;
      bf_set   = 1'b0;
      bf_clr   = 1'b0;
      ov_set   = 1'b0;
      coll_set = 1'b0;
      push     = 1'b0;

      // Pin synchronisers
      s_nxt.scl_s1   = scl_in;
      s_nxt.scl_s2   = s_r.scl_s1;
      s_nxt.sda_s1   = sda_in;
      s_nxt.sda_s2   = s_r.sda_s1;
      s_nxt.scl_prev = s_r.scl_s2;
      scl_hi         = s_r.scl_s2;
      sda_hi         = s_r.sda_s2;
      idle           = (s_r.state == ST_IDLE);

      // Bit timer, paused while a released SCL is held low
      stall = !s_r.scl_low && !scl_hi;
      tick  = s_r.timer_run && !stall && (s_r.tmr == TIMER_RST);
      if (s_r.timer_run && !stall && (s_r.tmr != TIMER_RST)) begin
         s_nxt.tmr = s_r.tmr - 8'h01;
      end

      // Buffer write: start when idle, else collide
      if (holding_buffer_wr_in) begin
         if (idle) begin
            s_nxt.holding_buffer = holding_buffer_wdata_in;
            s_nxt.shift_register = {holding_buffer_wdata_in[BYTE_W-2:0], 1'b0};
            s_nxt.sda_low        = !holding_buffer_wdata_in[BYTE_W-1];
            s_nxt.scl_low        = 1'b1;
            s_nxt.bit_cnt        = BIT_CNT_RST;
            s_nxt.state          = ST_TX_LOW;
            bf_set               = 1'b1;
            reload               = 1'b1;
         end else begin
            write_collision_flag_set = 1'b1;
         end
      end else if (idle && stop_request_set_in) begin
         s_nxt.stop_request     = 1'b1;
         s_nxt.sda_low = 1'b1;
         s_nxt.state   = ST_STOP_SDA;
      end else if (idle && restart_request_set_in) begin
         s_nxt.restart_request    = 1'b1;
         s_nxt.scl_low = 1'b1;
         s_nxt.state   = ST_RS_LOW;
      end else if (idle && receive_request_set_in && (s_r.fifo_cnt != FIFO_CNT_FULL)) begin
         s_nxt.receive_request    = 1'b1;
         s_nxt.sda_low = 1'b0;
         s_nxt.scl_low = 1'b1;
         s_nxt.bit_cnt = BIT_CNT_RST;
         s_nxt.state   = ST_RX_LOW;
         reload        = 1'b1;
      end else if (idle && ack_sequence_request_set_in) begin
         s_nxt.ack_sequence_request   = 1'b1;
         s_nxt.scl_low = 1'b1;
         s_nxt.sda_low = !ack_value_bit_in;
         s_nxt.state   = ST_ACK_LOW;
         reload        = 1'b1;
      end

      unique case (s_r.state)
         ST_IDLE: begin
         end
         ST_TX_LOW: begin
            if (tick) begin
               s_nxt.scl_low = 1'b0;
               s_nxt.state   = ST_TX_HIGH;
               reload        = 1'b1;
            end
         end
         ST_TX_HIGH: begin
            if (tick) begin
               s_nxt.scl_low = 1'b1;
               s_nxt.bit_cnt = s_r.bit_cnt + 4'h1;
               if (s_r.bit_cnt == ACK_CLK_IDX) begin
                  s_nxt.ack_result = sda_hi;
                  evt_set          = 1'b1;
                  halt             = 1'b1;
                  s_nxt.state      = ST_IDLE;
               end else if (s_r.bit_cnt == LAST_DATA_IDX) begin
                  bf_clr        = 1'b1;
                  s_nxt.sda_low = 1'b0;
                  s_nxt.state   = ST_TX_LOW;
                  reload        = 1'b1;
               end else begin
                  // Next bit in the same cycle as the falling edge
                  s_nxt.sda_low        = !s_r.shift_register[BYTE_W-1];
                  s_nxt.shift_register = {s_r.shift_register[BYTE_W-2:0], 1'b0};
                  s_nxt.state          = ST_TX_LOW;
                  reload               = 1'b1;
               end
            end
         end
         ST_RX_LOW: begin
            if (tick) begin
               s_nxt.scl_low = 1'b0;
               s_nxt.state   = ST_RX_HIGH;
               reload        = 1'b1;
            end
         end
         ST_RX_HIGH: begin
            if (tick) begin
               s_nxt.scl_low        = 1'b1;
               s_nxt.shift_register = {s_r.shift_register[BYTE_W-2:0], sda_hi};
               s_nxt.bit_cnt        = s_r.bit_cnt + 4'h1;
               if (s_r.bit_cnt == LAST_DATA_IDX) begin
                  s_nxt.receive_request           = 1'b0;
                  s_nxt.holding_buffer = {s_r.shift_register[BYTE_W-2:0], sda_hi};
                  bf_set               = 1'b1;
                  evt_set              = 1'b1;
                  ov_set               = s_r.bf;
                  push                 = 1'b1;
                  halt                 = 1'b1;
                  s_nxt.state          = ST_IDLE;
               end else begin
                  s_nxt.state = ST_RX_LOW;
                  reload      = 1'b1;
               end
            end
         end
         ST_ACK_LOW: begin
            if (tick) begin
               s_nxt.scl_low = 1'b0;
               s_nxt.state   = ST_ACK_HIGH;
               reload        = 1'b1;
            end
         end
         ST_ACK_HIGH: begin
            if (tick) begin
               s_nxt.scl_low = 1'b1;
               s_nxt.ack_sequence_request   = 1'b0;
               evt_set       = 1'b1;
               halt          = 1'b1;
               s_nxt.state   = ST_IDLE;
            end
         end
         ST_STOP_SDA: begin
            if (!sda_hi) begin
               s_nxt.state = ST_STOP_LOW;
               reload      = 1'b1;
            end
         end
         ST_STOP_LOW: begin
            if (tick) begin
               s_nxt.scl_low = 1'b0;
               s_nxt.state   = ST_STOP_HIGH;
               reload        = 1'b1;
            end
         end
         ST_STOP_HIGH: begin
            if (tick) begin
               s_nxt.sda_low = 1'b0;
               s_nxt.state   = ST_STOP_WAIT;
               halt          = 1'b1;
            end
         end
         ST_STOP_WAIT: begin
            if (sda_hi && scl_hi) begin
               s_nxt.stop_seen = 1'b1;
               s_nxt.state     = ST_STOP_END;
               reload          = 1'b1;
            end
         end
         ST_STOP_END: begin
            if (tick) begin
               s_nxt.stop_request   = 1'b0;
               evt_set     = 1'b1;
               halt        = 1'b1;
               s_nxt.state = ST_IDLE;
            end
         end
         ST_RS_LOW: begin
            if (!scl_hi) begin
               s_nxt.sda_low = 1'b0;
               s_nxt.state   = ST_RS_SDA;
               reload        = 1'b1;
            end
         end
         ST_RS_SDA: begin
            if (tick && sda_hi) begin
               s_nxt.scl_low = 1'b0;
               s_nxt.state   = ST_RS_SCL;
               reload        = 1'b1;
            end
         end
         ST_RS_SCL: begin
            if (scl_hi && !s_r.scl_prev && !sda_hi) begin
               coll_set = 1'b1;
            end else if (!scl_hi && s_r.scl_prev) begin
               coll_set = 1'b1;
            end else if (tick) begin
               s_nxt.sda_low = 1'b1;
               s_nxt.state   = ST_RS_SDA_LO;
               reload        = 1'b1;
            end
         end
         ST_RS_SDA_LO: begin
            if (tick) begin
               s_nxt.scl_low = 1'b1;
               s_nxt.restart_request    = 1'b0;
               evt_set       = 1'b1;
               halt          = 1'b1;
               s_nxt.state   = ST_IDLE;
            end
         end
      endcase

      // Collision aborts everything and frees the bus
      if (coll_set) begin
         s_nxt.state   = ST_IDLE;
         s_nxt.scl_low = 1'b0;
         s_nxt.sda_low = 1'b0;
         s_nxt.restart_request    = 1'b0;
         s_nxt.stop_request     = 1'b0;
         s_nxt.receive_request    = 1'b0;
         s_nxt.ack_sequence_request   = 1'b0;
         bf_clr        = 1'b1;
         halt          = 1'b1;
         reload        = 1'b0;
      end

      if (reload) begin
         s_nxt.tmr       = bit_timer_reload_in;
         s_nxt.timer_run = 1'b1;
      end else if (halt) begin
         s_nxt.timer_run = 1'b0;
      end

      // Reading clears buffer-full outside transmit
      if (holding_buffer_rd_in && (s_r.state != ST_TX_LOW) && (s_r.state != ST_TX_HIGH)) begin
         bf_clr = 1'b1;
      end

      // Sticky flags: a set in the clearing cycle wins
      s_nxt.bf        = bf_set | (s_r.bf & !bf_clr);
      s_nxt.evt       = evt_set | (s_r.evt & !serial_event_flag_clr_in);
      s_nxt.write_collision_flag      = write_collision_flag_set | (s_r.write_collision_flag & !write_collision_flag_clr_in);
      s_nxt.ov        = ov_set | (s_r.ov & !receive_overflow_flag_clr_in);
      s_nxt.coll      = coll_set | (s_r.coll & !collision_flag_clr_in);
      s_nxt.stop_seen = s_nxt.stop_seen & !(stop_seen_clr_in && (s_r.state != ST_STOP_WAIT));

      // Two-entry received byte buffer
      pop = rx_ready_in && (s_r.fifo_cnt != 2'h0);
      if (push) begin
         s_nxt.fifo_mem[s_r.fifo_wr] = s_nxt.holding_buffer;
         s_nxt.fifo_wr               = !s_r.fifo_wr;
      end
      if (pop) begin
         s_nxt.fifo_rd = !s_r.fifo_rd;
      end
      s_nxt.fifo_cnt = s_r.fifo_cnt + {1'b0, push} - {1'b0, pop};
   end

   always_ff @(posedge clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         s_r <= '{state: ST_IDLE, scl_s1: 1'b1, scl_s2: 1'b1, sda_s1: 1'b1, sda_s2: 1'b1,
                  scl_prev: 1'b1, tmr: TIMER_RST, bit_cnt: BIT_CNT_RST,
                  shift_register: BYTE_RST, holding_buffer: BYTE_RST, fifo_cnt: 2'h0,
                  default: '0};
      end else begin
         s_r <= s_nxt;
      end
   end

   assign scl_out                   = 1'b0;
   assign sda_out                   = 1'b0;
   assign scl_oe_out                = s_r.scl_low;
   assign sda_oe_out                = s_r.sda_low;
   assign holding_buffer_out        = s_r.holding_buffer;
   assign buffer_full_flag_out      = s_r.bf;
   assign write_collision_flag_out  = s_r.write_collision_flag;
   assign ack_result_flag_out       = s_r.ack_result;
   assign serial_event_flag_out     = s_r.evt;
   assign receive_overflow_flag_out = s_r.ov;
   assign collision_flag_out        = s_r.coll;
   assign stop_seen_out             = s_r.stop_seen;
   assign restart_request_out       = s_r.restart_request;
   assign stop_request_out          = s_r.stop_request;
   assign receive_request_out       = s_r.receive_request;
   assign ack_sequence_request_out  = s_r.ack_sequence_request;
   assign busy_out                  = (s_r.state != ST_IDLE);
   assign rx_valid_out              = (s_r.fifo_cnt != 2'h0);
   assign rx_data_out               = s_r.fifo_mem[s_r.fifo_rd];

endmodule : i2c_master_byte_engine

// ==== dv/i2c_engine_assertions.sv ====
/* Port-level checker for the two-wire master byte engine.
   Assumes one clock domain and the bind at the foot of this file. */
`timescale 1ns/1ps
module i2c_engine_checker (
   // Clock and reset
   input wire logic       clk_in,
   input wire logic       reset_n_in,
   // Software side
   input wire logic       holding_buffer_wr_in,
   input wire logic [7:0] holding_buffer_wdata_in,
   input wire logic       receive_request_set_in,
   // Engine outputs
   input wire logic       scl_oe_out,
   input wire logic       sda_oe_out,
   input wire logic [7:0] holding_buffer_out,
   input wire logic       buffer_full_flag_out,
   input wire logic       write_collision_flag_out,
   input wire logic       serial_event_flag_out,
   input wire logic       receive_overflow_flag_out,
   input wire logic       collision_flag_out,
   input wire logic       stop_seen_out,
   input wire logic       stop_request_out,
   input wire logic       receive_request_out,
   input wire logic       ack_sequence_request_out,
   input wire logic       busy_out
);
   default clocking @(posedge clk_in); endclocking
   default disable iff (!reset_n_in);

   AST_TX_START:
      assert property (!busy_out && holding_buffer_wr_in |=> busy_out && buffer_full_flag_out && scl_oe_out
         && sda_oe_out == !$past(holding_buffer_wdata_in[7])) else $error("transmit did not start");
   AST_WRITE_COLLISION_FLAG_SET:
      assert property (busy_out && holding_buffer_wr_in |=> write_collision_flag_out) else $error("no collision flag");
   AST_WRITE_COLLISION_FLAG_KEEP:
      assert property (busy_out && holding_buffer_wr_in && !receive_request_out |=> $stable(holding_buffer_out))
         else $error("buffer overwritten while busy");
   AST_RX_IGNORE:
      assert property (busy_out && receive_request_set_in && !receive_request_out |=> !receive_request_out)
         else $error("receive taken while busy");
   AST_RX_DONE:
      assert property ($fell(receive_request_out) |-> buffer_full_flag_out && serial_event_flag_out && scl_oe_out)
         else $error("receive end flags wrong");
   AST_RX_OVF:
      assert property ($rose(receive_overflow_flag_out) |-> $fell(receive_request_out))
         else $error("overflow outside byte end");
   AST_ACK_DONE:
      assert property ($fell(ack_sequence_request_out) && !collision_flag_out |-> serial_event_flag_out && scl_oe_out)
         else $error("acknowledge end wrong");
   AST_STOP_DONE:
      assert property ($fell(stop_request_out) && !collision_flag_out |-> serial_event_flag_out && stop_seen_out)
         else $error("stop end wrong");
   AST_COLL_IDLE:
      assert property ($rose(collision_flag_out) |-> !busy_out && !scl_oe_out && !sda_oe_out && !buffer_full_flag_out)
         else $error("collision did not idle");
endmodule : i2c_engine_checker

bind i2c_master_byte_engine i2c_engine_checker checker_i (.clk_in(clk_in), .reset_n_in(reset_n_in),
   .holding_buffer_wr_in(holding_buffer_wr_in), .holding_buffer_wdata_in(holding_buffer_wdata_in),
   .receive_request_set_in(receive_request_set_in), .scl_oe_out(scl_oe_out), .sda_oe_out(sda_oe_out),
   .holding_buffer_out(holding_buffer_out), .buffer_full_flag_out(buffer_full_flag_out),
   .write_collision_flag_out(write_collision_flag_out), .serial_event_flag_out(serial_event_flag_out),
   .receive_overflow_flag_out(receive_overflow_flag_out), .collision_flag_out(collision_flag_out),
   .stop_seen_out(stop_seen_out), .stop_request_out(stop_request_out), .receive_request_out(receive_request_out),
   .ack_sequence_request_out(ack_sequence_request_out), .busy_out(busy_out));

// ==== dv/i2c_target_model.sv ====
/* Behavioural bus target for the byte engine bench.
   Assumes resolved open-drain levels with pull-ups on scl_in and sda_in. */
`timescale 1ns/1ps
module i2c_target_model (
   input wire logic       scl_in,
   input wire logic       sda_in,
   input wire logic       frame_in,
   input wire logic       rd_mode_in,
   input wire logic       ack_en_in,
   input wire logic       scl_hold_in,
   input wire logic [7:0] rd_byte_in,
   output logic           sda_oe_out,
   output logic           scl_oe_out,
   output logic [7:0]     got_byte_out,
   output logic           ack_seen_out
);
   int cnt = 0;
   initial sda_oe_out = 1'b0;
   assign scl_oe_out = scl_hold_in;
   // Data only changes while SCL is low
   always @(negedge scl_in or posedge frame_in) begin
      cnt = frame_in ? 0 : cnt + 1;
      if (rd_mode_in)
         sda_oe_out = (cnt < 8) ? !rd_byte_in[7 - cnt] : 1'b0;
      else
         sda_oe_out = ack_en_in && cnt == 8;
   end
   always @(posedge scl_in) begin
      if (cnt < 8)
         got_byte_out = {got_byte_out[6:0], sda_in};
      else if (cnt == 8)
         ack_seen_out = sda_in;
   end
endmodule : i2c_target_model

// ==== dv/i2c_master_byte_engine_tb_top.sv ====
/* Self-checking bench for the byte engine against a bus target model.
   Assumes the package, engine, checker and target are compiled first. */
`timescale 1ns/1ps
module i2c_master_byte_engine_tb_top;
   import i2c_byte_engine_pkg::*;
   logic       clk_in = 0, reset_n_in = 0, wr = 0, ack_val = 0, rx_ready = 0, rd_mode = 0, ack_en = 0, scl_hold = 0;
   logic [7:0] pulse_r = 8'h00, wdata = 8'h00, rd_byte = 8'h00, rl = 8'h02;
   wire logic  scl, sda;
   logic       scl_oe, sda_oe, s_scl_oe, s_sda_oe, bf, write_collision_flag, ack_res, evt, ovf, coll, stop_seen;
   logic       rs_req, st_req, rc_req, ak_req, busy, rx_valid, ack_seen;
   logic [7:0] hb, got, rx_data;
   int         n_errors = 0, compares = 0;

   always #5 clk_in = ~clk_in;
   // Open-drain wires with pull-ups
   assign scl = !(scl_oe | s_scl_oe);
   assign sda = !(sda_oe | s_sda_oe);

   i2c_master_byte_engine i2c_master_byte_engine_i (.clk_in(clk_in), .reset_n_in(reset_n_in), .scl_in(scl),
      .scl_out(), .scl_oe_out(scl_oe), .sda_in(sda), .sda_out(), .sda_oe_out(sda_oe), .holding_buffer_wr_in(wr),
      .holding_buffer_wdata_in(wdata), .holding_buffer_rd_in(pulse_r[7]), .holding_buffer_out(hb),
      .bit_timer_reload_in(rl), .ack_value_bit_in(ack_val), .restart_request_set_in(pulse_r[0]),
      .stop_request_set_in(pulse_r[1]), .receive_request_set_in(pulse_r[2]), .ack_sequence_request_set_in(pulse_r[3]),
      .serial_event_flag_clr_in(pulse_r[4]), .write_collision_flag_clr_in(pulse_r[5]),
      .receive_overflow_flag_clr_in(1'b0), .collision_flag_clr_in(1'b0), .stop_seen_clr_in(1'b0),
      .buffer_full_flag_out(bf), .write_collision_flag_out(write_collision_flag), .ack_result_flag_out(ack_res),
      .serial_event_flag_out(evt), .receive_overflow_flag_out(ovf), .collision_flag_out(coll),
      .stop_seen_out(stop_seen), .restart_request_out(rs_req), .stop_request_out(st_req),
      .receive_request_out(rc_req), .ack_sequence_request_out(ak_req), .busy_out(busy),
      .rx_valid_out(rx_valid), .rx_ready_in(rx_ready), .rx_data_out(rx_data));

   i2c_target_model i2c_target_model_i (.scl_in(scl), .sda_in(sda), .frame_in(pulse_r[6]), .rd_mode_in(rd_mode),
      .ack_en_in(ack_en), .scl_hold_in(scl_hold), .rd_byte_in(rd_byte), .sda_oe_out(s_sda_oe),
      .scl_oe_out(s_scl_oe), .got_byte_out(got), .ack_seen_out(ack_seen));

   task chk1(input logic g, input logic e);
      compares++;
      if (g !== e) begin
         n_errors++;
         $display("unexpected at %0t: flag %b, wanted %b", $time, g, e);
      end
   endtask : chk1
   task chk8(input logic [7:0] g, input logic [7:0] e);
      compares++;
      if (g !== e) begin
         n_errors++;
         $display("unexpected at %0t: byte %h, wanted %h", $time, g, e);
      end
   endtask : chk8
   task report_and_stop;
      $display("compares %0d, mismatches %0d", compares, n_errors);
      if (n_errors == 0 && compares > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask : report_and_stop
   // Bits: restart, stop, receive, ack, event clr, write_collision_flag clr, frame, buffer read
   task pulse(input logic [7:0] v);
      @(negedge clk_in) pulse_r = v;
      @(negedge clk_in) pulse_r = 8'h00;
   endtask : pulse
   task wr_byte(input logic [7:0] d);
      @(negedge clk_in) begin wr = 1'b1; wdata = d; end
      @(negedge clk_in) wr = 1'b0;
   endtask : wr_byte
   task wait_done;
      for (int i = 0; i < 500 && busy !== 1'b0; i++) @(negedge clk_in);
      chk1(busy, 1'b0);
   endtask : wait_done
   task wait_scl(input logic v);
      for (int i = 0; i < 100 && scl !== v; i++) @(negedge clk_in);
      chk1(scl, v);
   endtask : wait_scl
   task t_tx(input logic [7:0] d, input logic a);
      rd_mode = 1'b0;
      ack_en = a;
      wr_byte(d);
      pulse(8'h40);
      chk1(bf, 1'b1);
      wr_byte(~d);
      chk1(write_collision_flag, 1'b1);
      chk8(hb, d);
      pulse(8'h01);
      chk1(rs_req, 1'b0);
      pulse(8'h04);
      chk1(rc_req, 1'b0);
      pulse(8'h20);
      wait_done;
      chk8(got, d);
      chk1(ack_res, !a);
      chk1(evt, 1'b1);
      chk1(scl_oe, 1'b1);
      chk1(bf, 1'b0);
      pulse(8'h10);
      $display("transmit test done");
   endtask : t_tx
   task t_rx(input logic [7:0] d, input logic o);
      rd_mode = 1'b1;
      rd_byte = d;
      pulse(8'h40);
      pulse(8'h04);
      wait_done;
      chk8(hb, d);
      chk1(bf, 1'b1);
      chk1(rc_req, 1'b0);
      chk1(scl_oe, 1'b1);
      chk1(ovf, o);
      pulse(8'h10);
      $display("receive test done");
   endtask : t_rx
   task t_ack(input logic v);
      int n;
      ack_val = v;
      pulse(8'h08);
      // Low phase of the acknowledge clock lasts reload plus one cycles
      n = 0;
      while (scl_oe === 1'b1 && n < 300) begin
         n++;
         @(negedge clk_in);
      end
      chk8(n[7:0], rl + 8'h01);
      wait_done;
      chk1(ack_seen, v);
      chk1(ak_req, 1'b0);
      chk1(evt, 1'b1);
      pulse(8'h10);
      $display("acknowledge test done");
   endtask : t_ack
   task t_drain;
      pulse(8'h04);
      chk1(rc_req, 1'b0);
      pulse(8'h80);
      chk1(bf, 1'b0);
      chk1(rx_valid, 1'b1);
      chk8(rx_data, 8'h5B);
      rx_ready = 1'b1;
      @(negedge clk_in) chk8(rx_data, 8'hC6);
      @(negedge clk_in) rx_ready = 1'b0;
      chk1(rx_valid, 1'b0);
      $display("drain test done");
   endtask : t_drain
   task t_stop;
      pulse(8'h02);
      wait_done;
      chk1(stop_seen, 1'b1);
      chk1(st_req, 1'b0);
      chk1(evt, 1'b1);
      chk1(scl & sda, 1'b1);
      pulse(8'h10);
      $display("stop test done");
   endtask : t_stop
   task t_coll;
      pulse(8'h01);
      wait_scl(1'b0);
      wait_scl(1'b1);
      // Let the synchroniser see SCL high before the other master pulls it
      @(negedge clk_in);
      scl_hold = 1'b1;
      wait_done;
      chk1(coll, 1'b1);
      chk1(rs_req | sda_oe, 1'b0);
      scl_hold = 1'b0;
      $display("collision test done");
   endtask : t_coll

   initial begin
      repeat (12) @(negedge clk_in);
      reset_n_in = 1'b1;
      repeat (3) @(negedge clk_in);
      t_tx(8'hA4, 1'b1);
      t_tx(8'h3C, 1'b0);
      t_rx(8'h5B, 1'b0);
      t_ack(1'b0);
      t_rx(8'hC6, 1'b1);
      t_drain;
      rl = 8'h05;
      t_ack(1'b1);
      rl = 8'h02;
      t_stop;
      t_coll;
      report_and_stop;
   end
   initial begin
      #100000;
      n_errors++;
      report_and_stop;
   end
endmodule : i2c_master_byte_engine_tb_top
